/* eil_top.sv */
// external interrupt latch: two active-low pins, request latches, AHB-Lite registers
// assumes: pins asynchronous to hclk; cpu supplies vector fetch strobe and address
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// external interrupt latch
// ****************************************************************
// Contract
// - separate latch per input
// - low input sets latch, falling edge
// - vector fetch clears its own request; input two's fetch does not clear it while cpu_req_one is set
// - software clear bit clears request
// - reset clears latches and sense bits
// - sense bit chooses edge or edge+level
// - level mode clears after ack and high
// - edge mode ack clears immediately
// - mask withholds request, keeps latch
// - edges after ack latch again
// - input one vector at FFFA/FFFB
// - input two vector at FFE0/FFE1
// - pending flag ignores mask
// - live pin one level for branches
// - clear bits read as zero
// - break blocks software clears unless enabled
// - unmasked request wakes processor
module eil_top
   import eil_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic ext_int_line_one_n,
   input wire logic ext_int_line_two_n,
   input wire logic vector_fetch,
   input wire logic [15:0] vector_addr,
   input wire logic break_state,
   output logic cpu_req_one,
   output logic cpu_req_two,
   output logic wake_req,
   output logic pin_one_level,
   output logic irq
);
   import eil_pkg::*;

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [1:0] sync_a_reg;
   logic [1:0] sync_b_reg;
   logic [1:0] pin_prev_reg;
   logic [2:0] prime_reg;
   // prime shifts in ones after reset; until the sync chain is full no edge counts
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prime_reg <= 3'h0;
      end else begin
         prime_reg <= {prime_reg[1:0], 1'b1};
      end
   end
   // set to one (pins idle high); a pin held low at reset then shows an edge, which prime masks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_a_reg <= 2'h3;
         sync_b_reg <= 2'h3;
         pin_prev_reg <= 2'h3;
      end else begin
         sync_a_reg <= {ext_int_line_two_n, ext_int_line_one_n};
         sync_b_reg <= sync_a_reg;
         pin_prev_reg <= sync_b_reg;
      end
   end

   // ****************************************************************
   // bus slave
   // ****************************************************************
   logic addr_ph_wr_reg;
   logic [7:0] addr_ph_reg;
   logic [1:0] pend_reg;
   logic [1:0] mask_reg;
   logic [1:0] sense_reg;
   logic [1:0] ack_seen_reg;
   logic [1:0] stat_reg;
   logic [1:0] imask_reg;
   logic brk_en_reg;
   wire bus_go = hsel && hready && (htrans == EIL_HTRANS_NONSEQ);
   wire wr_ctrl = addr_ph_wr_reg && (addr_ph_reg == EIL_CTRL_OFS);
   wire wr_stat = addr_ph_wr_reg && (addr_ph_reg == EIL_IRQ_STAT_OFS);
   wire wr_mask = addr_ph_wr_reg && (addr_ph_reg == EIL_IRQ_MASK_OFS);
   wire wr_brk = addr_ph_wr_reg && (addr_ph_reg == EIL_BRK_OFS);
   wire clr_allowed = !break_state || brk_en_reg;
   wire [1:0] sw_clr = (wr_ctrl && clr_allowed) ?
      {hwdata[EIL_CLR_TWO_BIT], hwdata[EIL_CLR_ONE_BIT]} : 2'h0;
   // clear bits are not stored: they read back zero
   wire [31:0] ctrl_view = {23'h0, sync_b_reg[0], sense_reg[1], sense_reg[0], mask_reg[1], mask_reg[0],
      2'h0, pend_reg[1], pend_reg[0]};
   wire [31:0] rd_mux =
      (haddr == EIL_CTRL_OFS) ? ctrl_view :
      (haddr == EIL_IRQ_STAT_OFS) ? {30'h0, stat_reg} :
      (haddr == EIL_IRQ_MASK_OFS) ? {30'h0, imask_reg} :
      (haddr == EIL_BRK_OFS) ? {31'h0, brk_en_reg} : 32'h0;

   // address phase capture, zero-wait read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_ph_wr_reg <= 1'b0;
         addr_ph_reg <= 8'h00;
         hrdata <= 32'h0;
      end else begin
         addr_ph_wr_reg <= bus_go && hwrite;
         addr_ph_reg <= haddr;
         hrdata <= (bus_go && !hwrite) ? rd_mux : 32'h0;
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // mask and sense bits, break enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_reg <= EIL_CTRL_RESET[EIL_MASK_TWO_BIT:EIL_MASK_ONE_BIT];
         sense_reg <= EIL_CTRL_RESET[EIL_SENSE_TWO_BIT:EIL_SENSE_ONE_BIT];
         brk_en_reg <= 1'b0;
         imask_reg <= 2'h0;
      end else begin
         if (wr_ctrl) begin
            mask_reg <= hwdata[EIL_MASK_TWO_BIT:EIL_MASK_ONE_BIT];
            sense_reg <= hwdata[EIL_SENSE_TWO_BIT:EIL_SENSE_ONE_BIT];
         end
         if (wr_brk) begin
            brk_en_reg <= hwdata[0];
         end
         if (wr_mask) begin
            imask_reg <= hwdata[1:0];
         end
      end
   end

   // ****************************************************************
   // request latches, one per input
   // ****************************************************************
   wire [1:0] vf_clr = {vector_fetch && cpu_req_two && !cpu_req_one &&
      (vector_addr == EIL_VEC_TWO_HI || vector_addr == EIL_VEC_TWO_LO),
      vector_fetch && cpu_req_one &&
      (vector_addr == EIL_VEC_ONE_HI || vector_addr == EIL_VEC_ONE_LO)};
   // a pin held low through reset must not look like a fresh edge
   wire [1:0] fall = (pin_prev_reg & ~sync_b_reg) & {2{prime_reg[2]}};
   wire [1:0] level_low = sense_reg & ~sync_b_reg;
   logic [1:0] pend_next;
   logic [1:0] ack_next;
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_line
         // a new edge wins over a same-cycle clear so it is never lost
         wire acked = vf_clr[gi] || sw_clr[gi];
         // level mode: ack stays pending until the pin returns high
         assign ack_next[gi] = sense_reg[gi] && (ack_seen_reg[gi] || acked) && !sync_b_reg[gi] && !fall[gi];
         // while the pin is low in level mode the request stays pending
         assign pend_next[gi] = fall[gi] ? 1'b1 :
            level_low[gi] ? 1'b1 :
            (acked || ack_seen_reg[gi]) ? 1'b0 : pend_reg[gi];
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_reg <= 2'h0;
         ack_seen_reg <= 2'h0;
      end else begin
         pend_reg <= pend_next;
         ack_seen_reg <= ack_next;
      end
   end

   // ****************************************************************
   // cpu side and interrupt status
   // ****************************************************************
   wire [1:0] new_pend = pend_next & ~pend_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpu_req_one <= 1'b0;
         cpu_req_two <= 1'b0;
         wake_req <= 1'b0;
         pin_one_level <= 1'b1;
         stat_reg <= 2'h0;
         irq <= 1'b0;
      end else begin
         cpu_req_one <= pend_next[0] && !mask_reg[0];
         cpu_req_two <= pend_next[1] && !mask_reg[1];
         wake_req <= |(pend_next & ~mask_reg);
         pin_one_level <= sync_b_reg[0];
         stat_reg <= new_pend | (stat_reg & ~(wr_stat ? hwdata[1:0] : 2'h0));
         irq <= |((new_pend | (stat_reg & ~(wr_stat ? hwdata[1:0] : 2'h0))) & imask_reg);
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   chk_reset_clear: assert property (@(posedge hclk) $rose(hresetn) |-> pend_reg == 2'h0)
      else $error("latch not clear after reset");
   chk_edge_sets: assert property (@(posedge hclk) disable iff (!hresetn) fall[0] |=> pend_reg[0])
      else $error("edge did not set request one");
   chk_edge_ack: assert property (@(posedge hclk) disable iff (!hresetn)
      !sense_reg[1] && sw_clr[1] && !fall[1] |=> !pend_reg[1])
      else $error("edge mode ack failed");
   chk_level_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      sense_reg[0] && !sync_b_reg[0] && !$past(sync_b_reg[0]) && !(ack_seen_reg[0]) && !sw_clr[0] && !vf_clr[0]
      |=> pend_reg[0])
      else $error("level request dropped while low");
   chk_mask_gate: assert property (@(posedge hclk) disable iff (!hresetn) mask_reg[0] |=> !cpu_req_one)
      else $error("masked request shown");
   chk_two_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      pend_next[1] && !mask_reg[1] |=> cpu_req_two)
      else $error("request two not presented");
   chk_wake_req: assert property (@(posedge hclk) disable iff (!hresetn)
      cpu_req_one || cpu_req_two |-> wake_req)
      else $error("wake missing");
   chk_break_block: assert property (@(posedge hclk) disable iff (!hresetn)
      break_state && !brk_en_reg |-> sw_clr == 2'h0)
      else $error("clear during break");
   chk_level_stays: assert property (@(posedge hclk) disable iff (!hresetn)
      sense_reg[0] && !sync_b_reg[0] |=> pend_reg[0])
      else $error("level request one dropped while pin low");
   chk_sw_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      !sense_reg[0] && sw_clr[0] && !fall[0] |=> !pend_reg[0])
      else $error("software clear of request one failed");
   chk_fetch_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      !sense_reg[0] && vf_clr[0] && !fall[0] |=> !pend_reg[0])
      else $error("vector fetch did not clear request one");
   chk_clear_reads_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      hrdata[EIL_CLR_TWO_BIT:EIL_CLR_ONE_BIT] == 2'h0)
      else $error("clear bits read back nonzero");
   chk_no_early_edge: assert property (@(posedge hclk) disable iff (!hresetn)
      !prime_reg[2] |=> pend_reg == 2'h0)
      else $error("request set while sync chain filling");
   chk_pin_track: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 pin_one_level == $past(sync_b_reg[0]))
      else $error("pin level wrong");
endmodule : eil_top
`default_nettype wire

/* eil_pkg.sv */
// package for the external interrupt latch block
// assumes: one 100 MHz bus clock, AHB-Lite register access, word-aligned registers
`default_nettype none
package eil_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0] EIL_CTRL_OFS = 8'h00; // status/control
   localparam logic [7:0] EIL_IRQ_STAT_OFS = 8'h04; // sticky event status, write one to clear
   localparam logic [7:0] EIL_IRQ_MASK_OFS = 8'h08; // interrupt enable mask
   localparam logic [7:0] EIL_BRK_OFS = 8'h0C; // break clear enable
   // ctrl field positions
   localparam int EIL_PEND_ONE_BIT = 0;
   localparam int EIL_PEND_TWO_BIT = 1;
   localparam int EIL_CLR_ONE_BIT = 2;
   localparam int EIL_CLR_TWO_BIT = 3;
   localparam int EIL_MASK_ONE_BIT = 4;
   localparam int EIL_MASK_TWO_BIT = 5;
   localparam int EIL_SENSE_ONE_BIT = 6;
   localparam int EIL_SENSE_TWO_BIT = 7;
   localparam int EIL_PIN_ONE_BIT = 8;
   localparam logic [31:0] EIL_CTRL_RESET = 32'h0000_0000;
   // vector addresses
   localparam logic [15:0] EIL_VEC_ONE_HI = 16'hFFFA;
   localparam logic [15:0] EIL_VEC_ONE_LO = 16'hFFFB;
   localparam logic [15:0] EIL_VEC_TWO_HI = 16'hFFE0;
   localparam logic [15:0] EIL_VEC_TWO_LO = 16'hFFE1;
   localparam logic [1:0] EIL_HTRANS_NONSEQ = 2'h2;
endpackage : eil_pkg
`default_nettype wire

/* eil_far.sv */
// far side model: two active-low interrupt pins and the cpu vector fetch
// assumes: the bench calls its tasks; everything moves just after hclk rises
`timescale 1ns/1ns
`default_nettype none
module eil_far (
   input wire logic hclk,
   output logic pin_one_n,
   output logic pin_two_n,
   output logic fetch,
   output logic [15:0] fetch_addr
);
   // pins idle high; the address bus shows junk outside a fetch
   initial begin
      pin_one_n = 1'b1;
      pin_two_n = 1'b1;
      fetch = 1'b0;
      fetch_addr = 16'h5A5A;
   end
   // pin change, then time for the two-flop sync and latch to settle
   task automatic drive_pin(input logic one, input logic v);
      @(posedge hclk);
      if (one) pin_one_n <= v;
      else pin_two_n <= v;
      repeat (6) @(posedge hclk);
   endtask : drive_pin
   // one-cycle fetch strobe; the address is inverted afterwards, not held
   task automatic fetch_vec(input logic [15:0] a);
      @(posedge hclk);
      fetch <= 1'b1;
      fetch_addr <= a;
      @(posedge hclk);
      fetch <= 1'b0;
      fetch_addr <= ~a;
      repeat (3) @(posedge hclk);
   endtask : fetch_vec
endmodule : eil_far
`default_nettype wire

/* tb.sv */
// self-checking bench for the external interrupt latch
// assumes: eil_pkg, eil_top and eil_far compiled first
`timescale 1ns/1ns
`default_nettype none
module tb;
   import eil_pkg::*;
   // ****************************************************************
   // clock, reset, bus signals
   // ****************************************************************
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic brk = 1'b0;
   logic [31:0] hrdata;
   logic [15:0] va;
   logic hready, hresp, p1, p2, vf, req1, req2, wake, pin_lvl, irq;
   int miscompares = 0;
   int check_count = 0;
   always #5 hclk = ~hclk;
   eil_far eil_far_inst (.hclk(hclk), .pin_one_n(p1), .pin_two_n(p2), .fetch(vf), .fetch_addr(va));
   eil_top eil_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
      .hresp(hresp), .ext_int_line_one_n(p1), .ext_int_line_two_n(p2), .vector_fetch(vf), .vector_addr(va),
      .break_state(brk), .cpu_req_one(req1), .cpu_req_two(req2), .wake_req(wake), .pin_one_level(pin_lvl),
      .irq(irq));
   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // bounded wait for hready; a hang ends the run as a failure
   task automatic rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 40);
      if (n >= 40) begin
         miscompares++;
         tally_and_finish();
      end
   endtask : rdy
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= EIL_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      r = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0000_0000, r);
      chk("register", exp, r);
   endtask : rd
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_edge();
      rd(EIL_CTRL_OFS, 32'h0000_0100);
      eil_far_inst.drive_pin(1'b1, 1'b0);
      rd(EIL_CTRL_OFS, 32'h0000_0001);
      chk("req one", 32'h1, req1);
      chk("pin level", 32'h0, pin_lvl);
      eil_far_inst.fetch_vec(EIL_VEC_TWO_HI);
      rd(EIL_CTRL_OFS, 32'h0000_0001);
      eil_far_inst.fetch_vec(EIL_VEC_ONE_LO);
      rd(EIL_CTRL_OFS, 32'h0000_0000);
      eil_far_inst.drive_pin(1'b1, 1'b1);
      eil_far_inst.drive_pin(1'b0, 1'b0);
      eil_far_inst.fetch_vec(EIL_VEC_TWO_LO);
      rd(EIL_CTRL_OFS, 32'h0000_0100);
      eil_far_inst.drive_pin(1'b0, 1'b1);
      $display("test edge done");
   endtask : t_edge
   // level mode: clear while low keeps it pending until the pin rises
   task automatic t_level();
      wr(EIL_CTRL_OFS, 32'h0000_0040);
      eil_far_inst.drive_pin(1'b1, 1'b0);
      wr(EIL_CTRL_OFS, 32'h0000_0044);
      rd(EIL_CTRL_OFS, 32'h0000_0041);
      eil_far_inst.drive_pin(1'b1, 1'b1);
      rd(EIL_CTRL_OFS, 32'h0000_0140);
      wr(EIL_CTRL_OFS, 32'h0000_0000);
      $display("test level done");
   endtask : t_level
   task automatic t_mask_irq();
      wr(EIL_CTRL_OFS, 32'h0000_0020);
      eil_far_inst.drive_pin(1'b0, 1'b0);
      rd(EIL_CTRL_OFS, 32'h0000_0122);
      chk("req two", 32'h0, req2);
      wr(EIL_IRQ_MASK_OFS, 32'h0000_0002);
      repeat (2) @(posedge hclk);
      chk("irq", 32'h1, irq);
      rd(EIL_IRQ_STAT_OFS, 32'h0000_0003);
      wr(EIL_IRQ_STAT_OFS, 32'h0000_0003);
      repeat (2) @(posedge hclk);
      chk("irq", 32'h0, irq);
      rd(8'h10, 32'h0000_0000);
      brk <= 1'b1;
      wr(EIL_CTRL_OFS, 32'h0000_0028);
      rd(EIL_CTRL_OFS, 32'h0000_0122);
      wr(EIL_BRK_OFS, 32'h0000_0001);
      wr(EIL_CTRL_OFS, 32'h0000_0028);
      brk <= 1'b0;
      rd(EIL_CTRL_OFS, 32'h0000_0120);
      eil_far_inst.drive_pin(1'b0, 1'b1);
      eil_far_inst.drive_pin(1'b0, 1'b0);
      rd(EIL_CTRL_OFS, 32'h0000_0122);
      $display("test mask and irq done");
   endtask : t_mask_irq
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      t_edge();
      t_level();
      t_mask_irq();
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
